//--- rtl/lts_line_test_seq.sv
`timescale 1ns/1ps

// Function
// (RQ1) Test mode only if select low at power-up
// (RQ2) Steps run 1 to 4 in order
// (RQ3) Steps 1, 2, 3 last 5 seconds
// (RQ4) Step 4 held; flags high, bias 128
// (RQ5) Bias code 0, 255, 128, 128
// (RQ6) Step 1 green low, others high; step 2 inverted
// (RQ7) Renewal flag low only in step 2
// (RQ8) Concentration pwm shows selected damper-open threshold
// (RQ9) Step 3 green follows warm-up setting input
// (RQ10) Step 3 red, damper follow adjustment inputs
// (RQ11) Step 3 fault follows reset-period setting input
// (RQ12) Reset returns everything to power-on state
// (RQ13) Normal concentration pwm spans 400 to 3000 ppm
// (RQ14) Threshold chosen from 8-bit select code bands
// (RQ15) Steps timed by clock; reset restarts at step 1
// (RQ16) Select high at power-up gives normal operation
module lts_line_test_seq
  import lts_pkg::*;
#(
  parameter int unsigned STEP_CYCLES_P = LTS_STEP_CYCLES  // cycles per timed step
) (
  input  wire logic        sys_clk_i,             // system clock, 50 MHz
  input  wire logic        sys_rst_i,             // async reset, active high
  input  wire logic        test_select_n_i,       // low at power-up selects line test
  input  wire logic        warmup_set_i,          // warm-up time setting pin
  input  wire logic        bench_adj_a_i,         // first benchmark-adjustment pin
  input  wire logic        bench_adj_b_i,         // second benchmark-adjustment pin
  input  wire logic        reset_period_set_i,    // auto benchmark-reset period pin
  input  wire logic [7:0]  threshold_code_i,      // converted threshold-select analog input
  input  wire logic [11:0] norm_ppm_i,            // normal mode concentration, ppm
  input  wire logic [7:0]  norm_bias_i,           // normal mode bias code
  input  wire logic        norm_green_i,          // normal mode green led level
  input  wire logic        norm_red_i,            // normal mode red led level
  input  wire logic        norm_damper_i,         // normal mode damper level
  input  wire logic        norm_fault_i,          // normal mode fault level
  input  wire logic        norm_renewed_i,        // normal mode renewal flag level
  output logic             concentration_pwm_o,   // concentration pwm
  output logic             bias_pwm_o,            // bias pwm
  output logic             green_led_o,           // green led
  output logic             red_led_o,             // red led
  output logic             damper_o,              // damper control
  output logic             fault_o,               // fault flag
  output logic             benchmark_renewed_o,   // benchmark-renewal flag
  output logic             line_test_active_o,    // high while in a test step
  output logic [2:0]       test_step_o            // current step 1..4, 0 otherwise
);

  // the counter width must hold the step length
  localparam logic [LTS_TIMER_W-1:0] STEP_LAST = LTS_TIMER_W'(STEP_CYCLES_P - 1);

  lts_seq_s   seq_r;          // registered sequencer state
  lts_seq_s   seq_nxt;        // next state
  logic [11:0] open_ppm;      // selected damper-open threshold, ppm
  logic [7:0]  open_code;     // that threshold as a pwm code
  logic [7:0]  norm_code;     // normal concentration as a pwm code
  logic        step_done;     // timed step has run its full length

  // threshold band decode from the select code
  always_comb begin
    if (threshold_code_i <= LTS_BAND0_MAX) begin  // RQ14
      open_ppm = LTS_OPEN_PPM0;
    end else if (threshold_code_i <= LTS_BAND1_MAX) begin
      open_ppm = LTS_OPEN_PPM1;
    end else if (threshold_code_i <= LTS_BAND2_MAX) begin
      open_ppm = LTS_OPEN_PPM2;
    end else if (threshold_code_i <= LTS_BAND3_MAX) begin
      open_ppm = LTS_OPEN_PPM3;
    end else begin
      open_ppm = LTS_OPEN_PPM4;
    end
  end

  // both mappings share the one ppm span, so test and normal read alike
  assign open_code = lts_ppm_to_code(open_ppm);    // RQ8
  assign norm_code = lts_ppm_to_code(norm_ppm_i);  // RQ13

  // end of a 5 second step, counted in clock cycles
  assign step_done = (seq_r.timer == STEP_LAST);   // RQ3 RQ15

  // next-state and output pattern
  always_comb begin
    seq_nxt = seq_r;
    unique case (seq_r.state)
      // first cycle after reset release: the strap is caught here, not
      // under reset, so the async reset only ever loads constants
      LTS_ST_CAPTURE: begin
        seq_nxt.timer = '0;
        if (!test_select_n_i) begin  // RQ1
          seq_nxt.state = LTS_ST_STEP1;  // RQ15
        end else begin
          seq_nxt.state = LTS_ST_NORMAL;  // RQ16
        end
      end
      // step 1: bias off, green low, the rest high
      LTS_ST_STEP1: begin
        seq_nxt.bias_code = LTS_BIAS_STEP1;  // RQ5
        seq_nxt.green     = 1'b0;  // RQ6
        seq_nxt.red       = 1'b1;
        seq_nxt.damper    = 1'b1;
        seq_nxt.fault     = 1'b1;
        seq_nxt.renewed   = 1'b1;  // RQ7
        seq_nxt.conc_code = open_code;  // RQ8
        if (step_done) begin
          seq_nxt.state = LTS_ST_STEP2;  // RQ2
          seq_nxt.timer = '0;
        end else begin
          seq_nxt.timer = seq_r.timer + 1'b1;
        end
      end
      // step 2: bias full, every flag of step 1 inverted
      LTS_ST_STEP2: begin
        seq_nxt.bias_code = LTS_BIAS_STEP2;  // RQ5
        seq_nxt.green     = 1'b1;  // RQ6
        seq_nxt.red       = 1'b0;
        seq_nxt.damper    = 1'b0;
        seq_nxt.fault     = 1'b0;
        seq_nxt.renewed   = 1'b0;  // RQ7
        seq_nxt.conc_code = open_code;  // RQ8
        if (step_done) begin
          seq_nxt.state = LTS_ST_STEP3;  // RQ2
          seq_nxt.timer = '0;
        end else begin
          seq_nxt.timer = seq_r.timer + 1'b1;
        end
      end
      // step 3: setting pins echoed to the outputs, one cycle late
      LTS_ST_STEP3: begin
        seq_nxt.bias_code = LTS_BIAS_STEP34;  // RQ5
        seq_nxt.green     = warmup_set_i;  // RQ9
        seq_nxt.red       = bench_adj_a_i;  // RQ10
        seq_nxt.damper    = bench_adj_b_i;  // RQ10
        seq_nxt.fault     = reset_period_set_i;  // RQ11
        seq_nxt.renewed   = 1'b1;  // RQ7
        seq_nxt.conc_code = open_code;  // RQ8
        if (step_done) begin
          seq_nxt.state = LTS_ST_STEP4;  // RQ2
          seq_nxt.timer = '0;
        end else begin
          seq_nxt.timer = seq_r.timer + 1'b1;
        end
      end
      // step 4: fixed pattern, no exit but reset or power loss
      LTS_ST_STEP4: begin
        seq_nxt.bias_code = LTS_BIAS_STEP34;  // RQ4 RQ5
        seq_nxt.green     = 1'b1;  // RQ4
        seq_nxt.red       = 1'b1;
        seq_nxt.damper    = 1'b1;
        seq_nxt.fault     = 1'b1;
        seq_nxt.renewed   = 1'b1;  // RQ7
        seq_nxt.conc_code = open_code;  // RQ8
        seq_nxt.timer     = '0;
      end
      // normal monitoring: outputs follow the monitoring logic's levels
      LTS_ST_NORMAL: begin
        seq_nxt.bias_code = norm_bias_i;
        seq_nxt.green     = norm_green_i;
        seq_nxt.red       = norm_red_i;
        seq_nxt.damper    = norm_damper_i;
        seq_nxt.fault     = norm_fault_i;
        seq_nxt.renewed   = norm_renewed_i;
        seq_nxt.conc_code = norm_code;  // RQ13
        seq_nxt.timer     = '0;
      end
      // the 3-bit code has two unused values; fall back to a fresh start
      default: begin
        seq_nxt       = '0;
        seq_nxt.state = LTS_ST_CAPTURE;
      end
    endcase
  end

  // state register; any reset pulse returns to the power-on state
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      seq_r <= '0;  // RQ12 RQ15
    end else begin
      seq_r <= seq_nxt;
    end
  end

  // concentration pwm
  lts_pwm u_conc_pwm (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .duty_i    (seq_r.conc_code),
    .pwm_o     (concentration_pwm_o)
  );

  // bias pwm
  lts_pwm u_bias_pwm (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .duty_i    (seq_r.bias_code),
    .pwm_o     (bias_pwm_o)
  );

  // flag outputs straight from the state register
  assign green_led_o         = seq_r.green;
  assign red_led_o           = seq_r.red;
  assign damper_o            = seq_r.damper;
  assign fault_o             = seq_r.fault;
  assign benchmark_renewed_o = seq_r.renewed;

  // step number for the fixture, decoded from the registered state
  always_comb begin
    unique case (seq_r.state)
      LTS_ST_STEP1: test_step_o = 3'h1;
      LTS_ST_STEP2: test_step_o = 3'h2;
      LTS_ST_STEP3: test_step_o = 3'h3;
      LTS_ST_STEP4: test_step_o = 3'h4;
      default:      test_step_o = 3'h0;
    endcase
  end

  assign line_test_active_o = (test_step_o != 3'h0);

endmodule // lts_line_test_seq

//--- rtl/lts_pkg.sv
package lts_pkg;

  // clock and step timing
  localparam int unsigned LTS_CLK_HZ      = 50_000_000;        // system clock rate
  localparam int unsigned LTS_STEP_TIME_S = 5;                 // length of steps 1 to 3
  localparam int unsigned LTS_STEP_CYCLES = LTS_STEP_TIME_S * LTS_CLK_HZ;
  localparam int          LTS_TIMER_W     = 28;                // holds 250e6 cycles

  // bias pwm codes per step
  localparam logic [7:0]  LTS_BIAS_STEP1  = 8'h00;
  localparam logic [7:0]  LTS_BIAS_STEP2  = 8'hFF;
  localparam logic [7:0]  LTS_BIAS_STEP34 = 8'h80;
  localparam logic [7:0]  LTS_BYTE_ZERO   = 8'h00;

  // upper edges of the threshold-select code bands
  localparam logic [7:0]  LTS_BAND0_MAX   = 8'h30;             // 48
  localparam logic [7:0]  LTS_BAND1_MAX   = 8'h60;             // 96
  localparam logic [7:0]  LTS_BAND2_MAX   = 8'h90;             // 144
  localparam logic [7:0]  LTS_BAND3_MAX   = 8'hC0;             // 192

  // damper-open thresholds in ppm
  localparam logic [11:0] LTS_OPEN_PPM0   = 12'h320;           // 800
  localparam logic [11:0] LTS_OPEN_PPM1   = 12'h3E8;           // 1000
  localparam logic [11:0] LTS_OPEN_PPM2   = 12'h5DC;           // 1500
  localparam logic [11:0] LTS_OPEN_PPM3   = 12'h7D0;           // 2000
  localparam logic [11:0] LTS_OPEN_PPM4   = 12'hBB8;           // 3000

  // concentration pwm span: 400 ppm gives code 0, 3000 ppm gives code 255
  localparam logic [11:0] LTS_PPM_MIN     = 12'h190;           // 400
  localparam logic [11:0] LTS_PPM_MAX     = 12'hBB8;           // 3000
  localparam logic [12:0] LTS_PPM_SCALE   = 13'h191C;          // 255/2600 in 16-bit fraction
  localparam int          LTS_SCALE_SHIFT = 16;

  // sequencer states, gray along capture -> step1..4, normal off the path
  typedef enum logic [2:0] {
    LTS_ST_CAPTURE = 3'h0,
    LTS_ST_STEP1   = 3'h1,
    LTS_ST_STEP2   = 3'h3,
    LTS_ST_STEP3   = 3'h2,
    LTS_ST_STEP4   = 3'h6,
    LTS_ST_NORMAL  = 3'h4
  } lts_state_e;

  // all sequencer state
  typedef struct packed {
    lts_state_e             state;
    logic [LTS_TIMER_W-1:0] timer;
    logic [7:0]             conc_code;
    logic [7:0]             bias_code;
    logic                   green;
    logic                   red;
    logic                   damper;
    logic                   fault;
    logic                   renewed;
  } lts_seq_s;

  // ppm to pwm code, clamped to the span; multiply-shift avoids a divider
  function automatic logic [7:0] lts_ppm_to_code(input logic [11:0] ppm);
    logic [11:0] clamped;
    logic [11:0] delta;
    logic [24:0] prod;
    clamped = (ppm < LTS_PPM_MIN) ? LTS_PPM_MIN : ((ppm > LTS_PPM_MAX) ? LTS_PPM_MAX : ppm);
    delta   = clamped - LTS_PPM_MIN;
    prod    = 25'(delta) * 25'(LTS_PPM_SCALE);
    return prod[LTS_SCALE_SHIFT+7:LTS_SCALE_SHIFT];
  endfunction

endpackage

//--- rtl/lts_pwm.sv
`timescale 1ns/1ps

// 8-bit pwm generator with a registered output
module lts_pwm
  import lts_pkg::*;
(
  input  wire logic       sys_clk_i,  // system clock
  input  wire logic       sys_rst_i,  // async reset, active high
  input  wire logic [7:0] duty_i,     // high time in 1/256 of a period
  output logic            pwm_o       // pwm wave
);

  typedef struct packed {
    logic [7:0] phase;                // free-running period counter
    logic       out;                  // registered wave
  } lts_pwm_s;

  lts_pwm_s pwm_r;                    // current state
  lts_pwm_s pwm_nxt;                  // next state

  // code 255 still leaves one low slot per period; kept so 0 is truly off
  always_comb begin
    pwm_nxt       = pwm_r;
    pwm_nxt.phase = pwm_r.phase + 8'h01;
    pwm_nxt.out   = (pwm_r.phase < duty_i);
  end

  // state register
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pwm_r <= '0;
    end else begin
      pwm_r <= pwm_nxt;
    end
  end

  assign pwm_o = pwm_r.out;

endmodule // lts_pwm

//--- testbench/lts_fixture.sv
`timescale 1ns/1ps
// production fixture model: drives the strap and the setting pins
module lts_fixture (
  input  wire logic       sys_clk_i,       // system clock, pins move on its falling edge
  output logic            test_select_n_o, // strap, low selects line test
  output logic [3:0]      set_o,           // warmup, adj a, adj b, period
  output logic [7:0]      thr_code_o       // converted threshold code
);
  logic [12:0] want_r = 13'h0000; // strap low from power-up on
  // the fixture holds the strap low while power comes up
  assign {test_select_n_o, set_o, thr_code_o} = want_r;
  // pins change on the next falling edge, half a period from sampling
  task automatic put(input logic s, input logic [3:0] st, input logic [7:0] t);
    @(negedge sys_clk_i);
    want_r = {s, st, t};
  endtask
endmodule // lts_fixture

//--- testbench/lts_seq_props.sv
`timescale 1ns/1ps
// step pattern checks seen at the sequencer ports
module lts_seq_props #(
  parameter int unsigned STEP_CYCLES_P = 20 // cycles per timed step
) (
  input wire logic       sys_clk_i,           // system clock
  input wire logic       sys_rst_i,           // async reset, active high
  input wire logic       test_select_n_i,     // line-test strap, low selects test
  input wire logic       warmup_set_i,        // warm-up setting pin
  input wire logic       bench_adj_a_i,       // first adjustment pin
  input wire logic       bench_adj_b_i,       // second adjustment pin
  input wire logic       reset_period_set_i,  // reset-period setting pin
  input wire logic       green_led_o,         // green led
  input wire logic       red_led_o,           // red led
  input wire logic       damper_o,            // damper control
  input wire logic       fault_o,             // fault flag
  input wire logic       benchmark_renewed_o, // renewal flag
  input wire logic       line_test_active_o,  // test running
  input wire logic [2:0] test_step_o          // current step number
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [2:0]  prev_r; // step number seen at the last edge
  int unsigned cnt_r;  // edges spent on that step number
  // counter restarts whenever the step number moves
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev_r <= 3'h0;
      cnt_r  <= 0;
    end else begin
      prev_r <= test_step_o;
      cnt_r  <= (test_step_o != prev_r) ? 1 : cnt_r + 1;
    end
  end
  AST_STEP1_FLAGS: assert property (
    test_step_o == 3'h1 && $past(test_step_o) == 3'h1 |-> !green_led_o && red_led_o
      && damper_o && fault_o && benchmark_renewed_o) else $error("step 1 pattern");
  AST_STEP2_FLAGS: assert property (
    test_step_o == 3'h2 && $past(test_step_o) == 3'h2 |-> green_led_o && !red_led_o
      && !damper_o && !fault_o && !benchmark_renewed_o) else $error("step 2 pattern");
  AST_STEP3_ECHO: assert property (
    test_step_o == 3'h3 && $past(test_step_o) == 3'h3 |-> green_led_o == $past(warmup_set_i)
      && red_led_o == $past(bench_adj_a_i) && damper_o == $past(bench_adj_b_i)
      && fault_o == $past(reset_period_set_i)) else $error("step 3 echo");
  AST_STEP4_FLAGS: assert property (
    test_step_o == 3'h4 && $past(test_step_o) == 3'h4 |-> green_led_o && red_led_o
      && damper_o && fault_o && benchmark_renewed_o) else $error("step 4 pattern");
  AST_STEP4_HOLD: assert property (
    test_step_o == 3'h4 |=> test_step_o == 3'h4 [*2]) else $error("step 4 left");
  AST_STEP_ORDER: assert property (
    $changed(test_step_o) |-> test_step_o == $past(test_step_o) + 3'h1)
    else $error("step order");
  AST_STEP_SHORT: assert property (
    test_step_o inside {3'h1, 3'h2, 3'h3} && test_step_o == prev_r |-> cnt_r < STEP_CYCLES_P)
    else $error("step too long");
  AST_STEP_EXACT: assert property (
    test_step_o != prev_r && prev_r inside {3'h1, 3'h2, 3'h3} |-> cnt_r == STEP_CYCLES_P)
    else $error("step length");
  // the test may only start in step 1, and only when the strap was low at capture
  AST_ACTIVE: assert property (
    $rose(line_test_active_o) |-> !$past(test_select_n_i) && test_step_o == 3'h1)
    else $error("active start");
endmodule // lts_seq_props
bind lts_line_test_seq lts_seq_props #(.STEP_CYCLES_P(STEP_CYCLES_P)) lts_seq_props_inst (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .test_select_n_i(test_select_n_i),
  .warmup_set_i(warmup_set_i),
  .bench_adj_a_i(bench_adj_a_i), .bench_adj_b_i(bench_adj_b_i),
  .reset_period_set_i(reset_period_set_i), .green_led_o(green_led_o),
  .red_led_o(red_led_o), .damper_o(damper_o), .fault_o(fault_o),
  .benchmark_renewed_o(benchmark_renewed_o), .line_test_active_o(line_test_active_o),
  .test_step_o(test_step_o));

//--- testbench/lts_line_test_seq_tb.sv
`timescale 1ns/1ps
module lts_line_test_seq_tb;
  localparam int unsigned P = 600;  // short step, long enough for duty windows
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        strap;
  logic [3:0]  set;                  // warmup, adj a, adj b, period
  logic [7:0]  thr;
  logic [11:0] nppm = 12'h190;       // normal-mode inputs
  logic [7:0]  nbias = 8'h00;
  logic [4:0]  nlv = 5'h00;          // green red damper fault renewed
  logic        conc, bias, gr, rd, dm, ft, rn, act;
  logic [2:0]  step;
  int          err_total = 0;
  int          comparisons = 0;
  lts_fixture lts_fixture_inst (.sys_clk_i(sys_clk_i), .test_select_n_o(strap),
    .set_o(set), .thr_code_o(thr));
  lts_line_test_seq #(.STEP_CYCLES_P(P)) lts_line_test_seq_inst (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .test_select_n_i(strap),
    .warmup_set_i(set[3]), .bench_adj_a_i(set[2]), .bench_adj_b_i(set[1]),
    .reset_period_set_i(set[0]), .threshold_code_i(thr), .norm_ppm_i(nppm),
    .norm_bias_i(nbias), .norm_green_i(nlv[4]), .norm_red_i(nlv[3]), .norm_damper_i(nlv[2]),
    .norm_fault_i(nlv[1]), .norm_renewed_i(nlv[0]), .concentration_pwm_o(conc),
    .bias_pwm_o(bias), .green_led_o(gr), .red_led_o(rd), .damper_o(dm), .fault_o(ft),
    .benchmark_renewed_o(rn), .line_test_active_o(act), .test_step_o(step));
  // free-running 50 MHz clock
  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // one compare; 9 bits so a full 256-high window cannot wrap to zero
  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  // any 256 consecutive cycles of a 256-period pwm hold exactly code highs
  task automatic duty(output logic [8:0] c, output logic [8:0] b);
    c = 9'h000;
    b = 9'h000;
    repeat (256) begin
      @(negedge sys_clk_i);
      c += conc;
      b += bias;
    end
  endtask
  // reset for 16 cycles with the given strap and threshold code
  task automatic boot(input logic s, input logic [7:0] t);
    lts_fixture_inst.put(s, 4'h0, t);
    sys_rst_i = 1'b1;
    repeat (16) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
  endtask
  // bounded wait for a step number
  task automatic wait_step(input logic [2:0] k);
    int n;
    n = 0;
    while (step !== k && n < 2000) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk(9'(step), 9'(k), "step reached");
  endtask
  // full sequence; strap raised after capture must be ignored
  task automatic t_seq();
    logic [8:0] c, b;
    logic [4:0] fl [4] = '{5'h0F, 5'h10, 5'h0B, 5'h1F};
    logic [7:0] bc [4] = '{8'h00, 8'hFF, 8'h80, 8'h80};
    time        t0;
    t0 = 0;
    boot(1'b0, 8'h31);
    for (int k = 1; k <= 4; k++) begin
      wait_step(3'(k));
      // every step is seen at the same negedge phase, so spacing is exact
      if (k > 1) begin
        chk(9'(($time - t0) == 20 * P), 9'h001, "step length");
      end
      t0 = $time;
      // step 3 gets a pin pattern that differs from every fixed step pattern
      lts_fixture_inst.put(1'b1, (k == 3) ? 4'h5 : 4'h0, 8'h31);
      repeat (4) @(negedge sys_clk_i);
      chk(9'({gr, rd, dm, ft, rn}), 9'(fl[k-1]), "flags");
      chk(9'(act), 9'h001, "active");
      duty(c, b);
      chk(b, 9'(bc[k-1]), "bias duty");
      chk(c, 9'h03A, "conc duty");
      if (k == 3) begin
        lts_fixture_inst.put(1'b1, 4'hA, 8'h31);
        repeat (3) @(negedge sys_clk_i);
        chk(9'({gr, rd, dm, ft, rn}), 9'h015, "echo");
      end
    end
    repeat (2 * P) @(negedge sys_clk_i);
    chk(9'(step), 9'h004, "held");
    $display("test sequence done");
  endtask
  // band edges of the threshold code while step 4 holds
  task automatic t_thr();
    logic [8:0] c, b;
    logic [7:0] cd [10] = '{8'h00, 8'h30, 8'h31, 8'h60, 8'h61, 8'h90, 8'h91, 8'hC0, 8'hC1, 8'hFF};
    int ppm [10] = '{800, 800, 1000, 1000, 1500, 1500, 2000, 2000, 3000, 3000};
    for (int i = 0; i < 10; i++) begin
      lts_fixture_inst.put(1'b1, 4'h0, cd[i]);
      repeat (4) @(negedge sys_clk_i);
      duty(c, b);
      chk(c, 9'(((ppm[i] - 400) * 6428) >>> 16), "band");
    end
    $display("test thresholds done");
  endtask
  // one-cycle reset in step 4 and in step 2 restarts at step 1
  task automatic t_midreset();
    lts_fixture_inst.put(1'b0, 4'h0, 8'h31);
    for (int r = 0; r < 2; r++) begin
      if (r == 1) wait_step(3'h2);
      @(negedge sys_clk_i);
      sys_rst_i = 1'b1;
      @(negedge sys_clk_i);
      chk(9'({step, gr, rd, dm, ft, rn}), 9'h000, "in reset");
      sys_rst_i = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      chk(9'(step), 9'h001, "restart");
    end
    $display("test midreset done");
  endtask
  // strap high: pass-through, clamped span, later strap low ignored
  task automatic t_normal();
    logic [8:0] c, b;
    boot(1'b1, 8'h00);
    nlv = 5'h15;
    nbias = 8'h40;
    nppm = 12'h0C8;
    repeat (10) @(negedge sys_clk_i);
    lts_fixture_inst.put(1'b0, 4'h0, 8'h00);
    repeat (10) @(negedge sys_clk_i);
    chk(9'({act, step}), 9'h000, "no test");
    chk(9'({gr, rd, dm, ft, rn}), 9'h015, "normal flags");
    duty(c, b);
    chk(c, 9'h000, "low clamp");
    chk(b, 9'h040, "normal bias");
    nppm = 12'hFFF;
    repeat (4) @(negedge sys_clk_i);
    duty(c, b);
    chk(c, 9'h0FF, "high clamp");
    $display("test normal done");
  endtask
  // verdict and end of run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // cuts a hang short
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    err_total++;
    report_and_stop();
  end
  initial begin
    t_seq();
    t_thr();
    t_midreset();
    t_normal();
    report_and_stop();
  end
endmodule // lts_line_test_seq_tb
